// ===== ebs_defs.svh
`ifndef EBS_DEFS_SVH
`define EBS_DEFS_SVH
// Summary of operation
// RULE1: Eight-byte LE access keeps low address 000b.
// RULE2: Eight-byte memory store drives all eight strobes.
// RULE3: Eight-byte transfer never goes out as PCI.
// RULE4: LE eight-byte store written fully byte-reversed.
// RULE5: Memory reads fetch eight bytes, strobes all zero.
// RULE6: PCI read word replicated onto both halves.
// RULE7: LE read data swapped before reaching processor.
// RULE8: Processor XORs half-word LE address with 110b.
// RULE9: Processor XORs word LE address with 100b.
// RULE10: Memory reads use address bits above low three.
// RULE11: Big-endian mode passes data through unchanged.
// RULE12: Request sampled always; select changes between transactions.
// RULE13: Select updates only when host and PCI idle.
// RULE14: System drives request active for LE processor.
// RULE15: Instruction fetches swap like data reads.
// RULE16: LE processor never issues unaligned bus cycles.
// RULE17: Size code plus low address pick lanes.
// RULE18: Bridge unmunges with 111/110/100 in LE only.
// RULE19: Swapper moves whole bytes, bit order kept.
// RULE20: Select shows big-endian after reset.

// ----------------------------------------
// Transfer size codes
// ----------------------------------------
`define EBS_SIZE_DWORD 3'h0
`define EBS_SIZE_BYTE 3'h1
`define EBS_SIZE_HALF 3'h2
`define EBS_SIZE_WORD 3'h4

// ----------------------------------------
// Low-order address XOR masks
// ----------------------------------------
`define EBS_XOR_BYTE 3'h7
`define EBS_XOR_HALF 3'h6
`define EBS_XOR_WORD 3'h4
`define EBS_XOR_NONE 3'h0

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define EBS_FIFO_DEPTH 4
`define EBS_STROBE_ALL_N 8'h00
`define EBS_SEL_BIG_N 1'b1
`endif

// ===== ebs_pkg.sv
package ebs_pkg;
  // ----------------------------------------
  // Request word carried through the FIFO
  // ----------------------------------------
  typedef struct packed {
    logic write;
    logic pci;
    logic [31:0] addr;
    logic [2:0] size;
    logic [63:0] wdata;
  } ebs_req_t;

  // ----------------------------------------
  // State encodings
  // ----------------------------------------
  typedef enum logic [2:0] {
    EBS_D_IDLE = 3'b000,
    EBS_D_MEM = 3'b001,
    EBS_D_MRD = 3'b010,
    EBS_D_PCI = 3'b011,
    EBS_D_PRD = 3'b100
  } ebs_dev_state_t;

  typedef enum logic [1:0] {
    EBS_H_IDLE = 2'b00,
    EBS_H_REQ = 2'b01,
    EBS_H_WAIT = 2'b10
  } ebs_host_state_t;
endpackage : ebs_pkg

// ===== ebs_link_if.sv
`timescale 1ns/10ps
interface ebs_link_if;
  // Request from processor side, held until taken
  logic req_valid;
  logic req_ready;
  logic req_write;
  logic req_pci;
  logic [31:0] req_addr;
  logic [2:0] req_size;
  logic [63:0] req_wdata;
  // Completion, one-cycle pulse
  logic resp_valid;
  logic resp_err;
  logic [63:0] resp_rdata;
  // Endian mode handshake, active low
  logic endian_request_n;
  logic endian_select_n;

  modport dev (
    input req_valid, req_write, req_pci, req_addr, req_size, req_wdata,
    input endian_request_n,
    output req_ready, resp_valid, resp_err, resp_rdata, endian_select_n
  );
  modport host (
    output req_valid, req_write, req_pci, req_addr, req_size, req_wdata,
    output endian_request_n,
    input req_ready, resp_valid, resp_err, resp_rdata, endian_select_n
  );
endinterface : ebs_link_if

// ===== ebs_fifo.sv
`timescale 1ns/10ps
module ebs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } ebs_fifo_state_t;

  ebs_fifo_state_t s_reg;
  ebs_fifo_state_t s_next;
  logic push;
  logic pop;

  // ----------------------------------------
  // Flags and next state
  // ----------------------------------------
  assign in_ready_o = (s_reg.cnt != CW'(DEPTH));
  assign out_valid_o = (s_reg.cnt != '0);
  assign out_data_o = s_reg.mem[s_reg.rp];
  assign push = in_valid_i & in_ready_o & ce_i;
  assign pop = out_valid_o & out_ready_i & ce_i;

  // Pointers wrap at the power-of-two depth
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data_i;
      s_next.wp = s_reg.wp + PW'(1);
    end
    if (pop) begin
      s_next.rp = s_reg.rp + PW'(1);
    end
    if (push && !pop) begin
      s_next.cnt = s_reg.cnt + CW'(1);
    end else if (pop && !push) begin
      s_next.cnt = s_reg.cnt - CW'(1);
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end
endmodule : ebs_fifo

// ===== ebs_bridge_end.sv
`timescale 1ns/10ps
`include "ebs_defs.svh"
module ebs_bridge_end (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Processor-side link
  ebs_link_if.dev link,
  // System memory port
  output logic mem_valid_o,
  input wire logic mem_ready_i,
  output logic mem_write_o,
  output logic [28:0] mem_dw_addr_o,
  output logic [7:0] mem_strobe_n_o,
  output logic [63:0] mem_wdata_o,
  input wire logic mem_rdata_valid_i,
  input wire logic [63:0] mem_rdata_i,
  // PCI port, one word per transaction
  output logic pci_valid_o,
  input wire logic pci_ready_i,
  output logic pci_write_o,
  output logic [31:0] pci_addr_o,
  output logic [3:0] pci_byte_en_n_o,
  output logic [31:0] pci_wdata_o,
  input wire logic pci_rdata_valid_i,
  input wire logic [31:0] pci_rdata_i,
  input wire logic pci_idle_i
);
  typedef struct packed {
    ebs_pkg::ebs_dev_state_t st;
    logic req_le;
    logic sel_le;
    logic write;
    logic mem_valid;
    logic [28:0] mem_dw_addr;
    logic [7:0] mem_strobe_n;
    logic [63:0] mem_wdata;
    logic pci_valid;
    logic [31:0] pci_addr;
    logic [3:0] pci_be_n;
    logic [31:0] pci_wdata;
    logic resp_valid;
    logic resp_err;
    logic [63:0] resp_rdata;
  } ebs_dev_reg_t;

  ebs_dev_reg_t s_reg;
  ebs_dev_reg_t s_next;
  ebs_pkg::ebs_req_t fifo_in;
  ebs_pkg::ebs_req_t cur;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [2:0] xor_mask;
  logic [2:0] unm;
  logic [7:0] lanes;
  logic [63:0] wswap;
  logic [31:0] whalf;
  logic size_ok;
  logic [63:0] pci_dbl;

  // ----------------------------------------
  // Byte helpers
  // ----------------------------------------
  // Lane k of a 64-bit bus is bits [63-8k -: 8]; whole bytes only
  function automatic logic [63:0] swap64(input logic [63:0] d);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[8*i +: 8] = d[63-8*i -: 8]; // RULE19
    end
    return r;
  endfunction : swap64

  function automatic logic [31:0] swap32(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction : swap32

  // Active lanes from unmunged offset and byte count
  function automatic logic [7:0] lane_mask(input logic [2:0] off, input logic [3:0] n);
    logic [7:0] m;
    m = '0;
    for (int k = 0; k < 8; k++) begin
      m[k] = (4'(k) >= {1'b0, off}) && (4'(k) < ({1'b0, off} + n));
    end
    return m;
  endfunction : lane_mask

  // ----------------------------------------
  // Request FIFO between link and bridge core
  // ----------------------------------------
  assign fifo_in = '{write: link.req_write, pci: link.req_pci, addr: link.req_addr,
                     size: link.req_size, wdata: link.req_wdata};
  assign fifo_out_ready = (s_reg.st == ebs_pkg::EBS_D_IDLE);

  ebs_fifo #(.WIDTH($bits(ebs_pkg::ebs_req_t)), .DEPTH(`EBS_FIFO_DEPTH)) u_req_fifo (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .in_valid_i(link.req_valid),
    .in_ready_o(link.req_ready),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(cur)
  );

  // ----------------------------------------
  // Unmunge and lane selection
  // ----------------------------------------
  always_comb begin
    xor_mask = `EBS_XOR_NONE;
    lanes = '0;
    size_ok = 1'b1;
    case (cur.size)
      `EBS_SIZE_BYTE: begin
        xor_mask = `EBS_XOR_BYTE;
        lanes = lane_mask(cur.addr[2:0] ^ (s_reg.sel_le ? `EBS_XOR_BYTE : 3'h0), 4'h1);
      end
      `EBS_SIZE_HALF: begin
        xor_mask = `EBS_XOR_HALF;
        lanes = lane_mask(cur.addr[2:0] ^ (s_reg.sel_le ? `EBS_XOR_HALF : 3'h0), 4'h2);
      end
      `EBS_SIZE_WORD: begin
        xor_mask = `EBS_XOR_WORD;
        lanes = lane_mask(cur.addr[2:0] ^ (s_reg.sel_le ? `EBS_XOR_WORD : 3'h0), 4'h4);
      end
      `EBS_SIZE_DWORD: begin
        // Double-word stays at offset 000b and never reaches PCI
        size_ok = (cur.addr[2:0] == 3'h0) && !cur.pci; // RULE1 RULE3
        lanes = 8'hff; // RULE2
      end
      default: begin
        size_ok = 1'b0;
      end
    endcase
  end

  // Unmunge only in little-endian mode
  assign unm = cur.addr[2:0] ^ (s_reg.sel_le ? xor_mask : 3'h0); // RULE18 RULE17
  // Swapper bypassed in big-endian mode
  assign wswap = s_reg.sel_le ? swap64(cur.wdata) : cur.wdata; // RULE4 RULE11
  assign whalf = unm[2] ? wswap[31:0] : wswap[63:32];
  assign pci_dbl = {swap32(pci_rdata_i), swap32(pci_rdata_i)}; // RULE6

  // ----------------------------------------
  // Transaction sequencer
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.resp_valid = 1'b0;
    // Request level is watched every cycle
    s_next.req_le = ~link.endian_request_n; // RULE12
    case (s_reg.st)
      ebs_pkg::EBS_D_IDLE: begin
        if (fifo_out_valid) begin
          s_next.write = cur.write;
          if (!size_ok) begin
            s_next.resp_valid = 1'b1;
            s_next.resp_err = 1'b1;
          end else if (cur.pci) begin
            s_next.st = ebs_pkg::EBS_D_PCI;
            s_next.pci_valid = 1'b1;
            s_next.pci_addr = {cur.addr[31:3], unm[2], 2'b00};
            s_next.pci_be_n = unm[2] ? ~lanes[7:4] : ~lanes[3:0];
            s_next.pci_wdata = swap32(whalf);
          end else begin
            s_next.st = ebs_pkg::EBS_D_MEM;
            s_next.mem_valid = 1'b1;
            s_next.mem_dw_addr = cur.addr[31:3]; // RULE10
            s_next.mem_wdata = wswap;
            // Reads always fetch the whole double-word
            s_next.mem_strobe_n = cur.write ? ~lanes : `EBS_STROBE_ALL_N; // RULE5
          end
        end else if (!link.req_valid && pci_idle_i) begin
          // Nothing queued, nothing pending on either bus
          s_next.sel_le = s_reg.req_le; // RULE12 RULE13
        end
      end
      ebs_pkg::EBS_D_MEM: begin
        if (mem_ready_i) begin
          s_next.mem_valid = 1'b0;
          s_next.st = s_reg.write ? ebs_pkg::EBS_D_IDLE : ebs_pkg::EBS_D_MRD;
          s_next.resp_valid = s_reg.write;
          s_next.resp_err = 1'b0;
        end
      end
      ebs_pkg::EBS_D_MRD: begin
        if (mem_rdata_valid_i) begin
          s_next.st = ebs_pkg::EBS_D_IDLE;
          s_next.resp_valid = 1'b1;
          s_next.resp_err = 1'b0;
          // Fetches and loads share this one path
          s_next.resp_rdata = s_reg.sel_le ? swap64(mem_rdata_i) : mem_rdata_i; // RULE7 RULE15
        end
      end
      ebs_pkg::EBS_D_PCI: begin
        if (pci_ready_i) begin
          s_next.pci_valid = 1'b0;
          s_next.st = s_reg.write ? ebs_pkg::EBS_D_IDLE : ebs_pkg::EBS_D_PRD;
          s_next.resp_valid = s_reg.write;
          s_next.resp_err = 1'b0;
        end
      end
      ebs_pkg::EBS_D_PRD: begin
        if (pci_rdata_valid_i) begin
          s_next.st = ebs_pkg::EBS_D_IDLE;
          s_next.resp_valid = 1'b1;
          s_next.resp_err = 1'b0;
          s_next.resp_rdata = s_reg.sel_le ? swap64(pci_dbl) : pci_dbl; // RULE7
        end
      end
      default: begin
        s_next.st = ebs_pkg::EBS_D_IDLE;
      end
    endcase
  end

  // State register; select comes up big-endian
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0; // RULE20
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.resp_valid = s_reg.resp_valid;
  assign link.resp_err = s_reg.resp_err;
  assign link.resp_rdata = s_reg.resp_rdata;
  assign link.endian_select_n = ~s_reg.sel_le;
  assign mem_valid_o = s_reg.mem_valid;
  assign mem_write_o = s_reg.write;
  assign mem_dw_addr_o = s_reg.mem_dw_addr;
  assign mem_strobe_n_o = s_reg.mem_strobe_n;
  assign mem_wdata_o = s_reg.mem_wdata;
  assign pci_valid_o = s_reg.pci_valid;
  assign pci_write_o = s_reg.write;
  assign pci_addr_o = s_reg.pci_addr;
  assign pci_byte_en_n_o = s_reg.pci_be_n;
  assign pci_wdata_o = s_reg.pci_wdata;
endmodule : ebs_bridge_end

// ===== ebs_cpu_end.sv
`timescale 1ns/10ps
`include "ebs_defs.svh"
module ebs_cpu_end (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Processor mode from software
  input wire logic le_mode_i,
  // Load/store command
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire logic cmd_pci_i,
  input wire logic [31:0] cmd_addr_i,
  input wire logic [2:0] cmd_size_i,
  input wire logic [63:0] cmd_wdata_i,
  // Completion
  output logic done_valid_o,
  output logic done_err_o,
  output logic [63:0] done_rdata_o,
  output logic align_fault_o,
  // Bridge link
  ebs_link_if.host link
);
  typedef struct packed {
    ebs_pkg::ebs_host_state_t st;
    logic req_n;
    logic write;
    logic pci;
    logic [31:0] addr;
    logic [2:0] size;
    logic [63:0] wdata;
    logic [5:0] shift;
    logic [63:0] keep;
    logic done_valid;
    logic done_err;
    logic [63:0] done_rdata;
    logic align_fault;
  } ebs_host_reg_t;

  ebs_host_reg_t s_reg;
  ebs_host_reg_t s_next;
  logic [2:0] munge;
  logic [3:0] nbytes;
  logic [2:0] moff;
  logic [5:0] shift;
  logic misaligned;

  // ----------------------------------------
  // Address munge and lane placement
  // ----------------------------------------
  always_comb begin
    munge = `EBS_XOR_NONE;
    nbytes = 4'h8;
    case (cmd_size_i)
      `EBS_SIZE_BYTE: begin
        munge = `EBS_XOR_BYTE;
        nbytes = 4'h1;
      end
      `EBS_SIZE_HALF: begin
        munge = `EBS_XOR_HALF; // RULE8
        nbytes = 4'h2;
      end
      `EBS_SIZE_WORD: begin
        munge = `EBS_XOR_WORD; // RULE9
        nbytes = 4'h4;
      end
      default: begin
        munge = `EBS_XOR_NONE; // RULE1
        nbytes = 4'h8;
      end
    endcase
  end

  assign moff = cmd_addr_i[2:0] ^ (le_mode_i ? munge : 3'h0);
  // Value sits in lanes moff..moff+n-1 of the big-endian bus
  assign shift = 6'((4'h8 - {1'b0, moff} - nbytes) << 3);
  // Little-endian mode traps any access not aligned to its size
  assign misaligned = le_mode_i && ((cmd_addr_i[2:0] & 3'(nbytes - 4'h1)) != 3'h0);

  // ----------------------------------------
  // Command sequencer, one access in flight
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.done_valid = 1'b0;
    s_next.align_fault = 1'b0;
    s_next.req_n = ~le_mode_i; // RULE14
    case (s_reg.st)
      ebs_pkg::EBS_H_IDLE: begin
        if (cmd_valid_i) begin
          if (misaligned) begin
            s_next.align_fault = 1'b1; // RULE16
          end else begin
            s_next.st = ebs_pkg::EBS_H_REQ;
            s_next.write = cmd_write_i;
            s_next.pci = cmd_pci_i;
            s_next.addr = {cmd_addr_i[31:3], moff};
            s_next.size = cmd_size_i;
            s_next.shift = shift;
            s_next.wdata = cmd_wdata_i << shift;
            s_next.keep = (nbytes == 4'h8) ? 64'hffff_ffff_ffff_ffff :
                          ((64'h1 << {nbytes, 3'h0}) - 64'h1);
          end
        end
      end
      ebs_pkg::EBS_H_REQ: begin
        if (link.req_ready) begin
          s_next.st = ebs_pkg::EBS_H_WAIT;
        end
      end
      ebs_pkg::EBS_H_WAIT: begin
        if (link.resp_valid) begin
          s_next.st = ebs_pkg::EBS_H_IDLE;
          s_next.done_valid = 1'b1;
          s_next.done_err = link.resp_err;
          s_next.done_rdata = (link.resp_rdata >> s_reg.shift) & s_reg.keep;
        end
      end
      default: begin
        s_next.st = ebs_pkg::EBS_H_IDLE;
      end
    endcase
  end

  // State register; request idles high (big-endian)
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '{st: ebs_pkg::EBS_H_IDLE, req_n: `EBS_SEL_BIG_N, default: '0};
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cmd_ready_o = (s_reg.st == ebs_pkg::EBS_H_IDLE) & ce_i;
  assign done_valid_o = s_reg.done_valid;
  assign done_err_o = s_reg.done_err;
  assign done_rdata_o = s_reg.done_rdata;
  assign align_fault_o = s_reg.align_fault;
  assign link.req_valid = (s_reg.st == ebs_pkg::EBS_H_REQ);
  assign link.req_write = s_reg.write;
  assign link.req_pci = s_reg.pci;
  assign link.req_addr = s_reg.addr;
  assign link.req_size = s_reg.size;
  assign link.req_wdata = s_reg.wdata;
  assign link.endian_request_n = s_reg.req_n;
endmodule : ebs_cpu_end

// ===== ebs_link_properties.sv
`timescale 1ns/10ps
module ebs_link_props (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Link signals
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_pci,
  input wire logic [31:0] req_addr,
  input wire logic [2:0] req_size,
  input wire logic resp_valid,
  input wire logic resp_err,
  input wire logic endian_request_n,
  input wire logic endian_select_n
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_take;
    req_valid && req_ready;
  endsequence
  // Refused transfers answer two edges after the take, with no far-side cycle
  sequence s_err_resp;
    ##2 (resp_valid && resp_err);
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_sel_reset;
    $rose(rstn_i) |-> endian_select_n && !resp_valid;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("select not big-endian after reset");

  // Request goes through two flops (req_le, then sel_le), so select trails it by two edges
  property p_sel_lag;
    $changed(endian_select_n) |-> endian_select_n == $past(endian_request_n, 2);
  endproperty
  a_sel_lag: assert property (p_sel_lag)
    else $error("select does not follow the request");

  property p_sel_idle;
    $changed(endian_select_n) |-> !$past(req_valid);
  endproperty
  a_sel_idle: assert property (p_sel_idle)
    else $error("select changed with a request pending");

  property p_err_pci;
    req_valid && req_ready && req_size == 3'h0 && req_pci |-> s_err_resp;
  endproperty
  a_err_pci: assert property (p_err_pci)
    else $error("eight-byte PCI transfer not refused");

  property p_err_off;
    req_valid && req_ready && req_size == 3'h0 && req_addr[2:0] != 3'h0 |-> s_err_resp;
  endproperty
  a_err_off: assert property (p_err_off)
    else $error("eight-byte access at nonzero offset not refused");

  property p_err_size;
    req_valid && req_ready && req_size inside {3'h3, 3'h5, 3'h6, 3'h7} |-> s_err_resp;
  endproperty
  a_err_size: assert property (p_err_size)
    else $error("unsupported size code not refused");

  property p_le_half;
    req_valid && req_ready && !endian_select_n && req_size == 3'h2 |-> !req_addr[0];
  endproperty
  a_le_half: assert property (p_le_half)
    else $error("little-endian half-word offset misaligned");

  property p_le_word;
    req_valid && req_ready && !endian_select_n && req_size == 3'h4 |-> req_addr[1:0] == 2'h0;
  endproperty
  a_le_word: assert property (p_le_word)
    else $error("little-endian word offset misaligned");

  // Memory and PCI stand-ins answer fast, so twelve edges is generous
  property p_resp_bound;
    s_take |-> ##[2:12] resp_valid;
  endproperty
  a_resp_bound: assert property (p_resp_bound)
    else $error("transfer never completed");
endmodule : ebs_link_props

// ===== endian_byte_swap_unmunge_bench.sv
`timescale 1ns/10ps
module endian_byte_swap_unmunge_bench;
  typedef struct packed {
    logic le;
    logic wr;
    logic pci;
    logic [31:0] addr;
    logic [2:0] size;
    logic [63:0] data;
    logic err;
    logic [7:0] en;
    logic [63:0] obs;
  } ebs_row_t;

  logic mclk_i = 1'b0, rstn_i = 1'b0;
  logic le_mode_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic cmd_write_i = 1'b0, cmd_pci_i = 1'b0;
  logic [31:0] cmd_addr_i = 32'h0;
  logic [2:0] cmd_size_i = 3'h0;
  logic [63:0] cmd_wdata_i = 64'h0;
  logic cmd_ready_o, done_valid_o, done_err_o, align_fault_o;
  logic [63:0] done_rdata_o, mem_wdata_o, mem_rdata_i;
  logic mem_valid_o, mem_write_o, pci_valid_o, pci_write_o;
  logic [28:0] mem_dw_addr_o;
  logic [7:0] mem_strobe_n_o;
  logic [31:0] pci_addr_o, pci_wdata_o, pci_rdata_i;
  logic [3:0] pci_byte_en_n_o;
  logic mem_ready_i = 1'b0, mem_rdata_valid_i = 1'b0;
  logic pci_ready_i = 1'b0, pci_rdata_valid_i = 1'b0;
  logic pci_idle_i = 1'b1, ce_i = 1'b1;
  logic rd_m = 1'b0, rd_p = 1'b0;
  logic [63:0] mem_q = 64'h0;
  logic [31:0] pci_q = 32'h0;
  logic [7:0] en_q = 8'h0;
  logic [31:0] addr_q = 32'h0;
  logic [1:0] got;
  int failures = 0, num_checks = 0;

  // All rows hit one double-word; errors leave the images untouched
  ebs_row_t rows [15] = '{
    '{0, 1, 0, 32'h1012, 3'h2, 64'h3132, 0, 8'hf3, 64'h0000313200000000},
    '{0, 0, 0, 32'h1012, 3'h2, 64'h0, 0, 8'h00, 64'h3132},
    '{0, 1, 0, 32'h1014, 3'h0, 64'h1, 1, 8'h00, 64'h0000313200000000},
    '{0, 1, 0, 32'h1010, 3'h3, 64'h1, 1, 8'h00, 64'h0000313200000000},
    '{0, 1, 1, 32'h1010, 3'h4, 64'h31323334, 0, 8'hf0, 64'h34333231},
    '{0, 0, 1, 32'h1014, 3'h4, 64'h0, 0, 8'hf0, 64'h31323334},
    '{0, 1, 1, 32'h1010, 3'h0, 64'h1, 1, 8'hf0, 64'h34333231},
    '{1, 1, 0, 32'h1012, 3'h2, 64'h3132, 0, 8'hf3, 64'h0000323100000000},
    '{1, 0, 0, 32'h1012, 3'h2, 64'h0, 0, 8'h00, 64'h3132},
    '{1, 1, 0, 32'h1014, 3'h4, 64'h31323334, 0, 8'h0f, 64'h0000323134333231},
    '{1, 1, 0, 32'h1010, 3'h0, 64'h3132333435363738, 0, 8'h00, 64'h3837363534333231},
    '{1, 0, 0, 32'h1010, 3'h0, 64'h0, 0, 8'h00, 64'h3132333435363738},
    '{1, 1, 0, 32'h1012, 3'h1, 64'h31, 0, 8'hfb, 64'h3837313534333231},
    '{1, 1, 1, 32'h1014, 3'h4, 64'h31323334, 0, 8'hf0, 64'h31323334},
    '{1, 0, 1, 32'h1014, 3'h4, 64'h0, 0, 8'hf0, 64'h31323334}
  };

  // ----------------------------------------
  // Design under test
  // ----------------------------------------
  ebs_link_if lnk ();
  ebs_cpu_end ebs_cpu_end_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .le_mode_i(le_mode_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_write_i(cmd_write_i), .cmd_pci_i(cmd_pci_i), .cmd_addr_i(cmd_addr_i),
    .cmd_size_i(cmd_size_i), .cmd_wdata_i(cmd_wdata_i), .done_valid_o(done_valid_o),
    .done_err_o(done_err_o), .done_rdata_o(done_rdata_o), .align_fault_o(align_fault_o),
    .link(lnk));
  ebs_bridge_end ebs_bridge_end_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .link(lnk), .mem_valid_o(mem_valid_o), .mem_ready_i(mem_ready_i),
    .mem_write_o(mem_write_o), .mem_dw_addr_o(mem_dw_addr_o), .mem_strobe_n_o(mem_strobe_n_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_valid_i(mem_rdata_valid_i), .mem_rdata_i(mem_rdata_i),
    .pci_valid_o(pci_valid_o), .pci_ready_i(pci_ready_i), .pci_write_o(pci_write_o),
    .pci_addr_o(pci_addr_o), .pci_byte_en_n_o(pci_byte_en_n_o), .pci_wdata_o(pci_wdata_o),
    .pci_rdata_valid_i(pci_rdata_valid_i), .pci_rdata_i(pci_rdata_i), .pci_idle_i(pci_idle_i));
  ebs_link_props ebs_link_props_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .req_valid(lnk.req_valid), .req_ready(lnk.req_ready), .req_pci(lnk.req_pci),
    .req_addr(lnk.req_addr), .req_size(lnk.req_size), .resp_valid(lnk.resp_valid),
    .resp_err(lnk.resp_err), .endian_request_n(lnk.endian_request_n),
    .endian_select_n(lnk.endian_select_n));

  // ----------------------------------------
  // Memory and PCI stand-ins
  // ----------------------------------------
  // Idle read data is inverted so stale data never passes
  assign mem_rdata_i = mem_rdata_valid_i ? mem_q : ~mem_q;
  assign pci_rdata_i = pci_rdata_valid_i ? pci_q : ~pci_q;

  // Capture sees the design's pre-edge outputs
  always @(posedge mclk_i) begin
    if (mem_valid_o && mem_ready_i) begin
      en_q = mem_strobe_n_o;
      addr_q = {mem_dw_addr_o, 3'h0};
      rd_m = !mem_write_o;
      for (int k = 0; k < 8; k++)
        if (mem_write_o && !mem_strobe_n_o[k]) mem_q[63-8*k-:8] = mem_wdata_o[63-8*k-:8];
    end
    if (pci_valid_o && pci_ready_i) begin
      en_q = {4'hf, pci_byte_en_n_o};
      addr_q = pci_addr_o;
      rd_p = !pci_write_o;
      for (int j = 0; j < 4; j++)
        if (pci_write_o && !pci_byte_en_n_o[j]) pci_q[8*j+:8] = pci_wdata_o[8*j+:8];
    end
  end

  // Ready at once, read data one cycle after the take
  always @(negedge mclk_i) begin
    mem_ready_i = mem_valid_o && !mem_ready_i;
    pci_ready_i = pci_valid_o && !pci_ready_i;
    mem_rdata_valid_i = rd_m;
    pci_rdata_valid_i = rd_p;
    rd_m = 1'b0;
    rd_p = 1'b0;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic set_mode(input logic le);
    le_mode_i = le;
    for (int n = 0; n < 20 && lnk.endian_select_n !== !le; n++) @(negedge mclk_i);
    chk(lnk.endian_select_n, !le);
  endtask : set_mode

  // Entered at a falling edge; got holds {fault, done}
  task automatic do_cmd(input ebs_row_t r);
    cmd_write_i = r.wr;
    cmd_pci_i = r.pci;
    cmd_addr_i = r.addr;
    cmd_size_i = r.size;
    cmd_wdata_i = r.data;
    cmd_valid_i = 1'b1;
    got = 2'b00;
    for (int n = 0; n < 50 && got == 2'b00; n++) begin
      @(posedge mclk_i);
      if (cmd_ready_o === 1'b1) cmd_valid_i <= 1'b0;
      @(negedge mclk_i);
      got = {align_fault_o, done_valid_o};
    end
  endtask : do_cmd

  // ----------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end

  initial begin
    #(50 * 4000);
    failures++;
    wrap_up();
  end

  initial begin
    repeat (20) @(negedge mclk_i);
    chk(lnk.endian_select_n, 1'b1);
    rstn_i = 1'b1;
    foreach (rows[i]) begin
      set_mode(rows[i].le);
      do_cmd(rows[i]);
      chk(got, 2'b01);
      chk(done_err_o, rows[i].err);
      chk(en_q, rows[i].en);
      if (!rows[i].wr) chk(done_rdata_o, rows[i].obs);
      else if (rows[i].pci) chk(pci_q, rows[i].obs);
      else chk(mem_q, rows[i].obs);
      if (!rows[i].err) chk(addr_q, rows[i].addr & (rows[i].pci ? ~32'h3 : ~32'h7));
    end
    // Misaligned LE half-word faults in the processor end
    do_cmd(ebs_row_t'{1, 0, 0, 32'h1013, 3'h2, 64'h0, 0, 8'h0, 64'h0});
    chk(got, 2'b10);
    // Busy PCI side holds the mode
    pci_idle_i = 1'b0;
    le_mode_i = 1'b0;
    repeat (10) @(negedge mclk_i);
    chk(lnk.endian_select_n, 1'b0);
    pci_idle_i = 1'b1;
    set_mode(1'b0);
    // Frozen enable holds the request; mid-run reset forces big-endian
    ce_i = 1'b0;
    le_mode_i = 1'b1;
    repeat (5) @(negedge mclk_i);
    chk(lnk.endian_request_n, 1'b1);
    ce_i = 1'b1;
    rstn_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk(lnk.endian_select_n, 1'b1);
    rstn_i = 1'b1;
    @(negedge mclk_i);
    chk(lnk.endian_select_n, 1'b1);
    wrap_up();
  end
endmodule : endian_byte_swap_unmunge_bench
